/* File: verilog/gpce_defines.vh */
// Constants for the 30-pin GPIO controller with edge, interrupt and wake logic
`ifndef GPCE_DEFINES_VH
`define GPCE_DEFINES_VH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define GPCE_NPINS        30
`define GPCE_ADDR_W       8
`define GPCE_DATA_W       32

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define GPCE_PIN_DIRECTION_REG      8'h00
`define GPCE_OUTPUT_SET_REG         8'h04
`define GPCE_OUTPUT_CLEAR_REG       8'h08
`define GPCE_PIN_LEVEL_REG          8'h0c
`define GPCE_RISING_EDGE_ENABLE_REG 8'h10
`define GPCE_FALLING_EDGE_ENABLE_REG 8'h14
`define GPCE_INTERRUPT_MASK_REG     8'h18
`define GPCE_WAKE_MASK_REG          8'h1c
`define GPCE_WAKE_SOURCE_REG        8'h20
`define GPCE_GLITCH_BYPASS_REG      8'h24
`define GPCE_INT_POLARITY_REG       8'h28
`define GPCE_INT_LEVEL_MODE_REG     8'h2c
`define GPCE_INT_STATUS_REG         8'h30
`define GPCE_OUTPUT_HIZ_REG         8'h34
`define GPCE_CONTROL_REG            8'h38

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define GPCE_CTRL_ROUTE_BIT  0
`define GPCE_PINS_RESET      30'h0000_0000
`define GPCE_ROUTE_RESET     1'h0

// ----------------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------------
`define GPCE_RESP_OKAY   2'h0
`define GPCE_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------------
// Glitch filter timing, reference clock 100 MHz
// ----------------------------------------------------------------------------
`define GPCE_FILT_MIN_NS     30
`define GPCE_FILT_REF_CLK_NS 10
`define GPCE_FILT_CYCLES     (`GPCE_FILT_MIN_NS / `GPCE_FILT_REF_CLK_NS)
`define GPCE_FILT_CNT_W      2

`endif

/* File: verilog/gpce_pin_filter.v */
// One pin: two-flop input stage and glitch filter with bypass select
`timescale 1ns/10ps
`include "gpce_defines.vh"

module gpce_pin_filter
(
  input  wire clk,       // Controller clock
  input  wire resetn,    // Synchronous reset, active low
  input  wire pinIn,     // Raw pad level
  input  wire bypass,    // Skip glitch filter
  output wire levelOut,  // Synchronised pad level
  output wire edgeSrc    // Level fed to edge detection
);

  localparam integer                LAST_INT = `GPCE_FILT_CYCLES - 1;
  localparam [`GPCE_FILT_CNT_W-1:0] LAST_CNT = LAST_INT[`GPCE_FILT_CNT_W-1:0];

  reg                        syncA_q;
  reg                        syncB_q;
  reg                        filt_q;
  reg [`GPCE_FILT_CNT_W-1:0] cnt_q;

  // --------------------------------------------------------------------------
  // Back to back flops, a synchroniser only; glitches pass on to the filter below
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      syncA_q <= 1'h0;
      syncB_q <= 1'h0;
    end
    else
    begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
    end
  end

  // --------------------------------------------------------------------------
  // Filter: a new level must hold for the full filter count
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      filt_q <= 1'h0;
      cnt_q  <= {`GPCE_FILT_CNT_W{1'b0}};
    end
    else if (syncB_q == filt_q)
    begin
      cnt_q <= {`GPCE_FILT_CNT_W{1'b0}};
    end
    else if (cnt_q == LAST_CNT)
    begin
      filt_q <= syncB_q;
      cnt_q  <= {`GPCE_FILT_CNT_W{1'b0}};
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign levelOut = syncB_q;
  assign edgeSrc  = bypass ? syncB_q : filt_q;

endmodule

/* File: verilog/gpce_top.v */
// GPIO controller: AXI4-Lite registers, pin drive, edge, interrupt and wake logic
`timescale 1ns/10ps
`include "gpce_defines.vh"

module gpce_top
(
  input  wire                       clk,      // Controller clock
  input  wire                       resetn,   // Synchronous reset, active low
  input  wire [`GPCE_ADDR_W-1:0]    awaddr,   // AXI write address
  input  wire                       awvalid,  // AXI write address valid
  output wire                       awready,  // AXI write address ready
  input  wire [`GPCE_DATA_W-1:0]    wdata,    // AXI write data
  input  wire [3:0]                 wstrb,    // AXI byte strobes
  input  wire                       wvalid,   // AXI write data valid
  output wire                       wready,   // AXI write data ready
  output reg  [1:0]                 bresp,    // AXI write response
  output reg                        bvalid,   // AXI write response valid
  input  wire                       bready,   // AXI write response ready
  input  wire [`GPCE_ADDR_W-1:0]    araddr,   // AXI read address
  input  wire                       arvalid,  // AXI read address valid
  output wire                       arready,  // AXI read address ready
  output reg  [`GPCE_DATA_W-1:0]    rdata,    // AXI read data
  output reg  [1:0]                 rresp,    // AXI read response
  output reg                        rvalid,   // AXI read data valid
  input  wire                       rready,   // AXI read data ready
  input  wire [`GPCE_NPINS-1:0]     padIn,    // Pad levels
  output wire [`GPCE_NPINS-1:0]     padOut,   // Pad output levels
  output wire [`GPCE_NPINS-1:0]     padOe_n,  // Pad drive enable, active low
  output wire                       irqCore,  // Controller interrupt to embedded core
  output wire                       irqHost,  // Controller interrupt to host
  output wire                       wakeReq   // Any wake source recorded
);

  localparam NP = `GPCE_NPINS;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [NP-1:0] dir_q;
  reg  [NP-1:0] outLatch_q;
  reg  [NP-1:0] riseEn_q;
  reg  [NP-1:0] fallEn_q;
  reg  [NP-1:0] intMask_q;
  reg  [NP-1:0] wakeMask_q;
  reg  [NP-1:0] wakeSrc_q;
  reg  [NP-1:0] bypass_q;
  reg  [NP-1:0] intPol_q;
  reg  [NP-1:0] intLvl_q;
  reg  [NP-1:0] intStat_q;
  reg  [NP-1:0] hiZ_q;
  reg           route_q;
  reg  [NP-1:0] edgeReg_q;

  reg                     awHeld_q;
  reg                     wHeld_q;
  reg  [`GPCE_ADDR_W-1:0] awAddr_q;
  reg  [`GPCE_DATA_W-1:0] wData_q;
  reg  [3:0]              wStrb_q;

  wire [NP-1:0] pinLevel;
  wire [NP-1:0] edgeSrc;
  wire [NP-1:0] riseDet;
  wire [NP-1:0] fallDet;
  wire [NP-1:0] edgeDet;
  wire [NP-1:0] pending;
  wire [`GPCE_DATA_W-1:0] byteMask;
  wire [NP-1:0] wMask;
  wire [NP-1:0] wBits;
  wire          doWrite;
  reg           wrHit;

  // --------------------------------------------------------------------------
  // Per-pin input stage
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1)
    begin : pinGen
      gpce_pin_filter uFilt
      (
        .clk      (clk),
        .resetn   (resetn),
        .pinIn    (padIn[gi]),
        .bypass   (bypass_q[gi]),
        .levelOut (pinLevel[gi]),
        .edgeSrc  (edgeSrc[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!resetn)
      edgeReg_q <= `GPCE_PINS_RESET;
    else
      edgeReg_q <= edgeSrc;
  end

  assign riseDet = edgeSrc & ~edgeReg_q & riseEn_q & ~dir_q;
  assign fallDet = ~edgeSrc & edgeReg_q & fallEn_q & ~dir_q;
  assign edgeDet = riseDet | fallDet;

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  assign padOut  = outLatch_q;
  assign padOe_n = ~(dir_q & ~hiZ_q);

  // --------------------------------------------------------------------------
  // Interrupt and wake outputs
  // --------------------------------------------------------------------------
  assign pending = intMask_q & ~dir_q &
                   ((intLvl_q & (pinLevel ^ intPol_q)) | (~intLvl_q & intStat_q));
  assign irqCore = (|pending) & ~route_q;
  assign irqHost = (|pending) & route_q;
  assign wakeReq = |wakeSrc_q;

  // --------------------------------------------------------------------------
  // AXI write channel
  // --------------------------------------------------------------------------
  assign awready  = ~awHeld_q;
  assign wready   = ~wHeld_q;
  assign doWrite  = awHeld_q & wHeld_q & ~bvalid;
  assign byteMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  assign wMask    = byteMask[NP-1:0];
  assign wBits    = wData_q[NP-1:0] & wMask;

  always @*
  begin
    wrHit = 1'b1;
    if (awAddr_q == `GPCE_PIN_DIRECTION_REG || awAddr_q == `GPCE_OUTPUT_SET_REG ||
        awAddr_q == `GPCE_OUTPUT_CLEAR_REG || awAddr_q == `GPCE_PIN_LEVEL_REG ||
        awAddr_q == `GPCE_RISING_EDGE_ENABLE_REG ||
        awAddr_q == `GPCE_FALLING_EDGE_ENABLE_REG ||
        awAddr_q == `GPCE_INTERRUPT_MASK_REG || awAddr_q == `GPCE_WAKE_MASK_REG ||
        awAddr_q == `GPCE_WAKE_SOURCE_REG || awAddr_q == `GPCE_GLITCH_BYPASS_REG ||
        awAddr_q == `GPCE_INT_POLARITY_REG || awAddr_q == `GPCE_INT_LEVEL_MODE_REG ||
        awAddr_q == `GPCE_INT_STATUS_REG || awAddr_q == `GPCE_OUTPUT_HIZ_REG ||
        awAddr_q == `GPCE_CONTROL_REG)
      wrHit = 1'b1;
    else
      wrHit = 1'b0;
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= {`GPCE_ADDR_W{1'b0}};
      wData_q  <= {`GPCE_DATA_W{1'b0}};
      wStrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `GPCE_RESP_OKAY;
    end
    else
    begin
      if (awvalid && !awHeld_q)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && !wHeld_q)
      begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wrHit ? `GPCE_RESP_OKAY : `GPCE_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Register updates
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      dir_q      <= `GPCE_PINS_RESET;
      outLatch_q <= `GPCE_PINS_RESET;
      riseEn_q   <= `GPCE_PINS_RESET;
      fallEn_q   <= `GPCE_PINS_RESET;
      intMask_q  <= `GPCE_PINS_RESET;
      wakeMask_q <= `GPCE_PINS_RESET;
      bypass_q   <= `GPCE_PINS_RESET;
      intPol_q   <= `GPCE_PINS_RESET;
      intLvl_q   <= `GPCE_PINS_RESET;
      hiZ_q      <= `GPCE_PINS_RESET;
      route_q    <= `GPCE_ROUTE_RESET;
    end
    else if (doWrite)
    begin
      if (awAddr_q == `GPCE_PIN_DIRECTION_REG)
        dir_q <= (dir_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_OUTPUT_SET_REG)
        outLatch_q <= outLatch_q | wBits;
      else if (awAddr_q == `GPCE_OUTPUT_CLEAR_REG)
        outLatch_q <= outLatch_q & ~wBits;
      else if (awAddr_q == `GPCE_RISING_EDGE_ENABLE_REG)
        riseEn_q <= (riseEn_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_FALLING_EDGE_ENABLE_REG)
        fallEn_q <= (fallEn_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_INTERRUPT_MASK_REG)
        intMask_q <= (intMask_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_WAKE_MASK_REG)
        wakeMask_q <= (wakeMask_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_GLITCH_BYPASS_REG)
        bypass_q <= (bypass_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_INT_POLARITY_REG)
        intPol_q <= (intPol_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_INT_LEVEL_MODE_REG)
        intLvl_q <= (intLvl_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_OUTPUT_HIZ_REG)
        hiZ_q <= (hiZ_q & ~wMask) | wBits;
      else if (awAddr_q == `GPCE_CONTROL_REG && wStrb_q[0])
        route_q <= wData_q[`GPCE_CTRL_ROUTE_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Sticky flags; a new event wins over a clear in the same cycle
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      wakeSrc_q <= `GPCE_PINS_RESET;
      intStat_q <= `GPCE_PINS_RESET;
    end
    else
    begin
      if (doWrite && awAddr_q == `GPCE_WAKE_SOURCE_REG)
        wakeSrc_q <= (wakeSrc_q & ~wBits) | (edgeDet & wakeMask_q);
      else
        wakeSrc_q <= wakeSrc_q | (edgeDet & wakeMask_q);
      if (doWrite && awAddr_q == `GPCE_INT_STATUS_REG)
        intStat_q <= (intStat_q & ~wBits) | edgeDet;
      else
        intStat_q <= intStat_q | edgeDet;
    end
  end

  // --------------------------------------------------------------------------
  // AXI read channel
  // --------------------------------------------------------------------------
  assign arready = ~rvalid;

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      rvalid <= 1'b0;
      rdata  <= {`GPCE_DATA_W{1'b0}};
      rresp  <= `GPCE_RESP_OKAY;
    end
    else if (arvalid && !rvalid)
    begin
      rvalid <= 1'b1;
      rresp  <= `GPCE_RESP_OKAY;
      if (araddr == `GPCE_PIN_DIRECTION_REG)
        rdata <= {2'h0, dir_q};
      else if (araddr == `GPCE_OUTPUT_SET_REG || araddr == `GPCE_OUTPUT_CLEAR_REG)
        rdata <= {2'h0, outLatch_q};
      else if (araddr == `GPCE_PIN_LEVEL_REG)
        rdata <= {2'h0, pinLevel};
      else if (araddr == `GPCE_RISING_EDGE_ENABLE_REG)
        rdata <= {2'h0, riseEn_q};
      else if (araddr == `GPCE_FALLING_EDGE_ENABLE_REG)
        rdata <= {2'h0, fallEn_q};
      else if (araddr == `GPCE_INTERRUPT_MASK_REG)
        rdata <= {2'h0, intMask_q};
      else if (araddr == `GPCE_WAKE_MASK_REG)
        rdata <= {2'h0, wakeMask_q};
      else if (araddr == `GPCE_WAKE_SOURCE_REG)
        rdata <= {2'h0, wakeSrc_q};
      else if (araddr == `GPCE_GLITCH_BYPASS_REG)
        rdata <= {2'h0, bypass_q};
      else if (araddr == `GPCE_INT_POLARITY_REG)
        rdata <= {2'h0, intPol_q};
      else if (araddr == `GPCE_INT_LEVEL_MODE_REG)
        rdata <= {2'h0, intLvl_q};
      else if (araddr == `GPCE_INT_STATUS_REG)
        rdata <= {2'h0, intStat_q};
      else if (araddr == `GPCE_OUTPUT_HIZ_REG)
        rdata <= {2'h0, hiZ_q};
      else if (araddr == `GPCE_CONTROL_REG)
        rdata <= {31'h0, route_q};
      else
      begin
        rdata <= {`GPCE_DATA_W{1'b0}};
        rresp <= `GPCE_RESP_SLVERR;
      end
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

endmodule

/* File: verification/gpce_props.sv */
// Port-level assertions for the GPIO controller
`timescale 1ns/10ps
`include "gpce_defines.vh"

module gpce_props
(
  input wire                    clk,      // Clock
  input wire                    resetn,   // Reset, active low
  input wire                    awvalid,  // AW valid
  input wire                    awready,  // AW ready
  input wire                    wvalid,   // W valid
  input wire                    wready,   // W ready
  input wire [1:0]              bresp,    // B code
  input wire                    bvalid,   // B valid
  input wire                    bready,   // B ready
  input wire                    arvalid,  // AR valid
  input wire                    arready,  // AR ready
  input wire [`GPCE_DATA_W-1:0] rdata,    // R data
  input wire [1:0]              rresp,    // R code
  input wire                    rvalid,   // R valid
  input wire                    rready,   // R ready
  input wire [`GPCE_NPINS-1:0]  padOut,   // Pad levels
  input wire [`GPCE_NPINS-1:0]  padOe_n,  // Drive enables
  input wire                    irqCore,  // Irq to core
  input wire                    irqHost,  // Irq to host
  input wire                    wakeReq   // Wake request
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_reset_no_drive: assert property ($rose(resetn) |-> &padOe_n && !bvalid && !rvalid)
    else $error("pads driven or answer pending after reset");
  a_write_answer: assert property (awvalid && awready && wvalid && wready && !bvalid
    |-> ##2 (bvalid && (bresp == `GPCE_RESP_OKAY || bresp == `GPCE_RESP_SLVERR)))
    else $error("write not answered two cycles after take");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered one cycle after take");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped before ready");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read answer dropped before ready");
  a_arready_rule: assert property (arready == !rvalid)
    else $error("read ready does not track pending answer");
  a_latch_by_write: assert property ($changed(padOut) && $past(resetn) |-> $rose(bvalid))
    else $error("output latch changed without a write");
  a_drive_by_write: assert property ($changed(padOe_n) && $past(resetn) |-> $rose(bvalid))
    else $error("drive enable changed without a write");
  a_wake_sticky: assert property ($fell(wakeReq) && $past(resetn) |-> $rose(bvalid))
    else $error("wake request cleared without a write");
  a_irq_single: assert property (!(irqCore && irqHost))
    else $error("interrupt routed to both targets");
endmodule

/* File: verification/gpce_pin_model.sv */
// Pad model: external drivers, design drive and floating pads
`timescale 1ns/10ps
`include "gpce_defines.vh"

module gpce_pin_model
(
  input  wire                   clk,       // Clock for float pattern
  input  wire [`GPCE_NPINS-1:0] padOut,    // Design output levels
  input  wire [`GPCE_NPINS-1:0] padOe_n,   // Design drive enables
  input  wire [`GPCE_NPINS-1:0] extLevel,  // External driver level
  input  wire [`GPCE_NPINS-1:0] extEn,     // External driver enable
  output wire [`GPCE_NPINS-1:0] padIn      // Resolved pad level
);
  reg [`GPCE_NPINS-1:0] float_q = 30'h15555555;

  // Undriven pads change every cycle so no stale level is read
  always @(posedge clk)
    float_q <= ~float_q;

  // Pads always routed here, one owner
  assign padIn = (~padOe_n & padOut) | (padOe_n & extEn & extLevel)
               | (padOe_n & ~extEn & float_q);
endmodule

/* File: verification/gpce_top_test.sv */
// Self-checking bench for the GPIO controller
`timescale 1ns/10ps
`include "gpce_defines.vh"

module gpce_top_test;
  reg         clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, rd, wm, wd;
  reg  [3:0]  wstrb;
  reg  [1:0]  rr;
  reg  [29:0] extLevel, extEn, mDir, mLat, mRise, mFall, mIm, mWm, mWake, mByp, mPol;
  reg  [29:0] mLvl, mStat, mHiz;
  reg         mRoute;
  wire        awready, wready, bvalid, arready, rvalid, irqCore, irqHost, wakeReq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [29:0] padIn, padOut, padOe_n;
  integer     failures, total_checks, seed;

  gpce_top gpce_top_i (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .padIn(padIn), .padOut(padOut), .padOe_n(padOe_n), .irqCore(irqCore),
    .irqHost(irqHost), .wakeReq(wakeReq));
  gpce_pin_model gpce_pin_model_i (.clk(clk), .padOut(padOut), .padOe_n(padOe_n),
    .extLevel(extLevel), .extEn(extEn), .padIn(padIn));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----
  // Model and compares
  // ----
  function [29:0] pins();
    pins = (mDir & ~mHiz & mLat) | (~(mDir & ~mHiz) & extLevel);
  endfunction
  function irqE();
    irqE = |(mIm & ~mDir & ((mStat & ~mLvl) | (mLvl & (pins() ^ mPol))));
  endfunction
  function [29:0] upd(input [29:0] o);
    upd = (o & ~wm[29:0]) | wd[29:0];
  endfunction
  function [31:0] expRd(input [7:0] a);
    case (a)
      8'h00: expRd = {2'h0, mDir};
      8'h04, 8'h08: expRd = {2'h0, mLat};
      8'h0c: expRd = {2'h0, pins()};
      8'h10: expRd = {2'h0, mRise};
      8'h14: expRd = {2'h0, mFall};
      8'h18: expRd = {2'h0, mIm};
      8'h1c: expRd = {2'h0, mWm};
      8'h20: expRd = {2'h0, mWake};
      8'h24: expRd = {2'h0, mByp};
      8'h28: expRd = {2'h0, mPol};
      8'h2c: expRd = {2'h0, mLvl};
      8'h30: expRd = {2'h0, mStat};
      8'h34: expRd = {2'h0, mHiz};
      8'h38: expRd = {31'h0, mRoute};
      default: expRd = 32'h0;
    endcase
  endfunction

  task print_verdict;
    begin
      if (failures == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] name, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("[ERR] %0s expected %h seen %h", name, e, g);
      end
    end
  endtask
  task tmo(input integer n);
    if (n >= 40)
    begin
      failures = failures + 1;
      print_verdict;
    end
  endtask

  // ----
  // Bus master
  // ----
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40 && !(bvalid && bready); n = n + 1)
      begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end
      rr = bresp;
      bready <= 1'b0;
      tmo(n);
      chk("bresp", (a > 8'h38) ? `GPCE_RESP_SLVERR : `GPCE_RESP_OKAY, rr);
      wm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      wd = d & wm;
      case (a)
        8'h00: mDir = upd(mDir);
        8'h04: mLat = mLat | wd[29:0];
        8'h08: mLat = mLat & ~wd[29:0];
        8'h10: mRise = upd(mRise);
        8'h14: mFall = upd(mFall);
        8'h18: mIm = upd(mIm);
        8'h1c: mWm = upd(mWm);
        8'h20: mWake = mWake & ~wd[29:0];
        8'h24: mByp = upd(mByp);
        8'h28: mPol = upd(mPol);
        8'h2c: mLvl = upd(mLvl);
        8'h30: mStat = mStat & ~wd[29:0];
        8'h34: mHiz = upd(mHiz);
        8'h38: if (wm[0]) mRoute = wd[0];
        default: ;
      endcase
    end
  endtask
  task rdr(input [7:0] a);
    integer n;
    begin
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 40 && !(rvalid && rready); n = n + 1)
      begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
      end
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
      tmo(n);
    end
  endtask

  // Waits out sync, filter and edge stages, then compares all outputs and register reads, masking level bits of floating pads
  task chk_all;
    integer a;
    reg [31:0] km;
    begin
      repeat (12) @(posedge clk);
      chk("padOut", {2'h0, mLat}, {2'h0, padOut});
      chk("padOe_n", {2'h0, ~(mDir & ~mHiz)}, {2'h0, padOe_n});
      chk("irqCore", {31'h0, irqE() & !mRoute}, {31'h0, irqCore});
      chk("irqHost", {31'h0, irqE() & mRoute}, {31'h0, irqHost});
      chk("wakeReq", {31'h0, |mWake}, {31'h0, wakeReq});
      for (a = 0; a <= 8'h3c; a = a + 4)
      begin
        rdr(a[7:0]);
        km = (a == 8'h0c) ? {2'h0, (mDir & ~mHiz) | extEn} : 32'hffffffff;
        chk("rdata", expRd(a[7:0]) & km, rd & km);
        chk("rresp", (a > 8'h38) ? `GPCE_RESP_SLVERR : `GPCE_RESP_OKAY, rr);
      end
    end
  endtask

  task pulse(input integer b, input integer w);
    begin
      @(posedge clk);
      extLevel[b] <= ~extLevel[b];
      repeat (w) @(posedge clk);
      extLevel[b] <= ~extLevel[b];
    end
  endtask
  task ev(input [29:0] m);
    begin
      mWake = mWake | (m & mWm);
      mStat = mStat | m;
    end
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    seed = 94080; failures = 0; total_checks = 0; resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = 0;
    {mDir, mLat, mRise, mFall, mIm, mWm, mWake, mByp, mPol, mLvl, mStat, mHiz} = 0;
    mRoute = 1'b0; extLevel = 30'h0; extEn = 30'h3fffffff;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    chk_all;
    wr(8'h0c, 32'hffffffff, 4'hf);
    wr(8'h40, 32'hffffffff, 4'hf);
    wr(8'h04, $random(seed), 4'hf);
    chk_all;
    extEn <= 30'h0;
    wr(8'h00, 32'hffffffff, 4'hf);
    chk_all;
    wr(8'h08, $random(seed), 4'hf);
    chk_all;
    wr(8'h34, 32'h0000ff00, 4'hf);
    wr(8'h38, 32'h1, 4'he);
    chk_all;
    wr(8'h00, 32'h0, 4'hf);
    extEn <= 30'h3fffffff;
    extLevel <= $random(seed) & 30'h3ffffc00;
    wr(8'h10, 32'h5, 4'hf);
    wr(8'h14, 32'h8, 4'hf);
    wr(8'h24, 32'h4, 4'hf);
    wr(8'h1c, 32'hffffffff, 4'hf);
    wr(8'h18, 32'h9, 4'hf);
    chk_all;
    pulse(0, 2);
    chk_all;
    pulse(0, 6);
    ev(30'h1);
    chk_all;
    pulse(2, 1);
    ev(30'h4);
    chk_all;
    pulse(3, 10);
    ev(30'h8);
    chk_all;
    wr(8'h18, 32'h0, 4'hf);
    chk_all;
    wr(8'h30, 32'h1, 4'hf);
    wr(8'h18, 32'h9, 4'hf);
    chk_all;
    wr(8'h30, 32'h8, 4'hf);
    wr(8'h2c, 32'h10, 4'hf);
    wr(8'h28, 32'h10, 4'hf);
    wr(8'h18, 32'h10, 4'hf);
    wr(8'h38, 32'h1, 4'hf);
    chk_all;
    extLevel[4] <= 1'b1;
    chk_all;
    wr(8'h20, 32'hffffffff, 4'hf);
    chk_all;
    print_verdict;
  end
endmodule

bind gpce_top gpce_props gpce_props_i (.clk(clk), .resetn(resetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .padOut(padOut), .padOe_n(padOe_n),
  .irqCore(irqCore), .irqHost(irqHost), .wakeReq(wakeReq));
